/* File: src/ebp_regs.svh */
// Timing and field constants for the external bus pin control block
// How it works
// - 8-bit muxed: low byte address, then data
// - 16-bit muxed: all lines address, then data
// - 8-bit muxed: high byte holds address 8-15
// - 16-bit demuxed: all lines data whole cycle
// - 8-bit demuxed: low byte data whole cycle
// - 8-bit demuxed: high byte shows internal bus
// - Address valid low only for external accesses
// - Address valid marks valid address on bus
// - Address valid low whole cycle, high after
`ifndef EBP_REGS_SVH
`define EBP_REGS_SVH
// Default clocks in each half of a bus cycle; at least three,
// as read data reaches the sequencer two clocks late
`define EBP_HALF_CYCLES_DEF 3
// Field positions of the address/data bytes
`define EBP_LO_MSB 7
`define EBP_LO_LSB 0
`define EBP_HI_MSB 15
`define EBP_HI_LSB 8
// Idle value of the strobe and drive enables
`define EBP_ADV_IDLE 1'b1
`define EBP_OE_OFF 8'h00
`define EBP_OE_ON 8'hff
`define EBP_WORD_ZERO 16'h0000
// Read lanes used in 8-bit and 16-bit modes
`define EBP_LO_LANES 16'h00ff
`define EBP_ALL_LANES 16'hffff
`endif

/* File: src/ebp_pkg.sv */
// Types shared by the external bus pin control block
package ebp_pkg;
  // Bus mode: multiplexing and width
  typedef enum logic [1:0] {
    EBP_MUX8 = 2'h0,
    EBP_MUX16 = 2'h1,
    EBP_DMX8 = 2'h2,
    EBP_DMX16 = 2'h3
  } ebp_mode_e;

  // One access request from the core
  typedef struct packed {
    ebp_mode_e mode;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ebp_req_s;

  // Pin drive group for the address/data lines
  typedef struct packed {
    logic [15:0] dout;
    logic [15:0] oe;
  } ebp_pins_s;
endpackage

/* File: src/ebp_pin_mux.sv */
// Address/data line drive selection per bus mode and half
`timescale 1ns/1ps
`default_nettype none
`include "ebp_regs.svh"
module ebp_pin_mux
  import ebp_pkg::*;
(
  input wire logic active,
  input wire logic second_half,
  input var ebp_req_s req,
  input wire logic [7:0] int_high_byte,
  output var ebp_pins_s pins
);
  logic [7:0] lo_d;
  logic [7:0] hi_d;
  logic [7:0] lo_oe;
  logic [7:0] hi_oe;
  logic drv_data;

  // Pick each byte's value and enable from mode and half
  always_comb begin
    drv_data = req.write;
    lo_d = req.wdata[`EBP_LO_MSB:`EBP_LO_LSB];
    hi_d = req.wdata[`EBP_HI_MSB:`EBP_HI_LSB];
    lo_oe = drv_data ? `EBP_OE_ON : `EBP_OE_OFF;
    hi_oe = drv_data ? `EBP_OE_ON : `EBP_OE_OFF;
    case (req.mode)
      EBP_MUX8: begin
        hi_d = req.addr[`EBP_HI_MSB:`EBP_HI_LSB];
        hi_oe = `EBP_OE_ON;
        if (!second_half) begin
          lo_d = req.addr[`EBP_LO_MSB:`EBP_LO_LSB];
          lo_oe = `EBP_OE_ON;
        end
      end
      EBP_MUX16: begin
        if (!second_half) begin
          lo_d = req.addr[`EBP_LO_MSB:`EBP_LO_LSB];
          hi_d = req.addr[`EBP_HI_MSB:`EBP_HI_LSB];
          lo_oe = `EBP_OE_ON;
          hi_oe = `EBP_OE_ON;
        end
      end
      EBP_DMX8: begin
        lo_d = req.wdata[`EBP_LO_MSB:`EBP_LO_LSB];
        hi_d = int_high_byte;
        hi_oe = `EBP_OE_ON;
      end
      EBP_DMX16: begin
        lo_d = req.wdata[`EBP_LO_MSB:`EBP_LO_LSB];
        hi_d = req.wdata[`EBP_HI_MSB:`EBP_HI_LSB];
      end
      default: begin
        lo_oe = `EBP_OE_OFF;
        hi_oe = `EBP_OE_OFF;
      end
    endcase
    if (!active) begin
      lo_oe = `EBP_OE_OFF;
      hi_oe = `EBP_OE_OFF;
    end
    pins.dout = {hi_d, lo_d};
    pins.oe = {hi_oe, lo_oe};
  end
endmodule // ebp_pin_mux
`default_nettype wire

/* File: src/ebp_bus_ctrl.sv */
// Bus cycle sequencer for the external address/data bus
`timescale 1ns/1ps
`default_nettype none
`include "ebp_regs.svh"
module ebp_bus_ctrl
  import ebp_pkg::*;
#(
  parameter int HALF_CYCLES = `EBP_HALF_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_external,
  input var ebp_req_s req_in,
  input wire logic [7:0] int_high_byte,
  input wire logic [15:0] addr_data_lines_in,
  output logic req_ready,
  output logic done,
  output logic [15:0] rdata,
  output logic [15:0] addr_data_lines_out,
  output logic [15:0] addr_data_lines_oe,
  output logic address_valid_n
);
  //--------------------------------------------------------------
  // Phase counter sizing
  //--------------------------------------------------------------
  // Counter wide enough to hold HALF_CYCLES without wrapping
  localparam int CW = $clog2(HALF_CYCLES + 1);
  // Count value on the last clock of each half
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  //--------------------------------------------------------------
  // Mode decode
  //--------------------------------------------------------------
  // Modes whose data rides on the low byte only
  function automatic logic is_byte_mode(input ebp_mode_e mode);
    return (mode == EBP_MUX8) || (mode == EBP_DMX8);
  endfunction

  // Read lanes that carry data in a given mode
  function automatic logic [15:0] read_lanes(input ebp_mode_e mode);
    return is_byte_mode(mode) ? `EBP_LO_LANES : `EBP_ALL_LANES;
  endfunction

  //--------------------------------------------------------------
  // Reset release
  //--------------------------------------------------------------
  // Reset asserts at once but leaves on a clock edge, two flops
  // later, so no flop sees its release close to an edge
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  //--------------------------------------------------------------
  // Pin input synchroniser
  //--------------------------------------------------------------
  // Lines come from outside the clock domain; only the second
  // flop feeds any logic
  logic [15:0] ad_s1_q;
  logic [15:0] ad_s2_q;
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ad_s1_q <= `EBP_WORD_ZERO;
      ad_s2_q <= `EBP_WORD_ZERO;
    end else begin
      ad_s1_q <= addr_data_lines_in;
      ad_s2_q <= ad_s1_q;
    end
  end

  //--------------------------------------------------------------
  // Bus cycle sequencer
  //--------------------------------------------------------------
  // Outline of one external access taken on edge c0:
  //   after c0       strobe low, first half on the lines
  //   after c0+H     second half on the lines
  //   after c0+2H    strobe high, done pulse, read word valid
  // The read word is the line value two clocks before the end,
  // as the synchroniser lags, so a half needs three clocks
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, // No bus cycle running
    ST_FIRST = 3'h2, // Address half, or data in demux
    ST_SECOND = 3'h4 // Data half
  } ebp_state_e;

  ebp_state_e state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  ebp_req_s req_q, req_d;
  logic [15:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic adv_n_q, adv_n_d;
  logic last_tick;
  logic take;
  logic idle;

  // Only external accesses start a bus cycle
  assign take = req_valid && req_external;
  // Internal accesses never wait on the external bus
  assign idle = (state_q == ST_IDLE);
  assign req_ready = idle || !req_external;
  // Last clock of the running half
  assign last_tick = (cnt_q == LAST);

  // Next state, strobe and done pulse
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    req_d = req_q;
    done_d = 1'b0;
    adv_n_d = adv_n_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_FIRST;
          req_d = req_in;
          cnt_d = '0;
          adv_n_d = 1'b0;
        end
      end
      ST_FIRST: begin
        cnt_d = last_tick ? '0 : cnt_q + 1'b1;
        if (last_tick) begin
          state_d = ST_SECOND;
        end
      end
      ST_SECOND: begin
        cnt_d = cnt_q + 1'b1;
        if (last_tick) begin
          state_d = ST_IDLE;
          done_d = 1'b1;
          adv_n_d = `EBP_ADV_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        adv_n_d = `EBP_ADV_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      req_q <= '0;
      done_q <= 1'b0;
      adv_n_q <= `EBP_ADV_IDLE;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      done_q <= done_d;
      adv_n_q <= adv_n_d;
    end
  end

  //--------------------------------------------------------------
  // Read capture
  //--------------------------------------------------------------
  logic capture;

  // Take the synchronised lines on the closing edge of a read
  assign capture = (state_q == ST_SECOND) && last_tick && !req_q.write;

  // Unused high byte reads as zero in 8-bit modes
  always_comb begin
    rdata_d = rdata_q;
    if (capture) begin
      rdata_d = ad_s2_q & read_lanes(req_q.mode);
    end
  end

  // Read word register
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= `EBP_WORD_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  //--------------------------------------------------------------
  // Pin drive
  //--------------------------------------------------------------
  ebp_pins_s pins_c;
  ebp_pins_s pins_q;
  logic mux_active;
  logic mux_second;

  // Next-state view so the registered pins line up with the strobe
  assign mux_active = (state_d != ST_IDLE);
  assign mux_second = (state_d == ST_SECOND);

  // Per-mode choice of drive value and enable
  ebp_pin_mux u_mux (
    .active(mux_active),
    .second_half(mux_second),
    .req(req_d),
    .int_high_byte(int_high_byte),
    .pins(pins_c)
  );

  // Register pin drive aligned with the strobe
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins_c;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  // Every pin-side output comes straight from a flip-flop
  assign addr_data_lines_out = pins_q.dout;
  assign addr_data_lines_oe = pins_q.oe; // High while we drive a line
  assign address_valid_n = adv_n_q;
  assign done = done_q; // One clock at the end of a cycle
  assign rdata = rdata_q; // Holds until the next read ends
endmodule // ebp_bus_ctrl
`default_nettype wire

/* File: testbench/ebp_monitor.sv */
// Port checker for the external bus sequencer
`timescale 1ns/1ps
`default_nettype none
module ebp_monitor
  import ebp_pkg::*;
#(
  parameter int HALF_CYCLES = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_external,
  input wire logic req_ready,
  input var ebp_req_s req_in,
  input wire logic [7:0] int_high_byte,
  input wire logic done,
  input wire logic address_valid_n,
  input wire logic [15:0] addr_data_lines_out,
  input wire logic [15:0] addr_data_lines_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Clocks from strobe fall to the done pulse
  localparam int CYC = 2 * HALF_CYCLES;
  wire logic take = req_valid && req_external && req_ready;
  wire logic low = !address_valid_n;
  ebp_req_s cur_q;
  // Request held for the running cycle
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) cur_q <= '0;
    else if (take) cur_q <= req_in;
  a_adv_start: assert property (take |=> low)
    else $error("strobe missing after take");
  a_int_quiet: assert property (
    req_valid && !req_external && address_valid_n |=> address_valid_n)
    else $error("internal strobe");
  a_oe_idle: assert property (
    address_valid_n |-> addr_data_lines_oe == 16'h0000)
    else $error("lines driven idle");
  a_done_high: assert property (
    done |-> address_valid_n ##1 !done)
    else $error("strobe low at done");
  a_fall_done: assert property (
    $fell(address_valid_n) |-> ##[CYC:CYC] done)
    else $error("cycle length wrong");
  a_low_until: assert property (
    $fell(address_valid_n) |-> low until done)
    else $error("strobe rose early");
  a_hi_mux8: assert property (
    low && cur_q.mode == EBP_MUX8 |->
    addr_data_lines_out[15:8] == cur_q.addr[15:8])
    else $error("high byte");
  a_addr_first: assert property (
    $fell(address_valid_n) && !cur_q.mode[1] |->
    addr_data_lines_out == cur_q.addr)
    else $error("address phase");
  a_dmx_data: assert property (
    low && cur_q.mode == EBP_DMX16 && cur_q.write |->
    addr_data_lines_out == cur_q.wdata)
    else $error("demux data");
  a_dmx8_high: assert property (
    low && cur_q.mode == EBP_DMX8 |->
    addr_data_lines_out[15:8] == $past(int_high_byte))
    else $error("internal byte");
  cover property (take && req_in.mode == EBP_MUX8);
  cover property (done && !cur_q.write);
  cover property (req_valid && !req_external);
endmodule // ebp_monitor
bind ebp_bus_ctrl ebp_monitor #(.HALF_CYCLES(HALF_CYCLES)) mon (.*);
`default_nettype wire

/* File: testbench/ebp_ext_mem.sv */
// Far-side memory with address latch
`timescale 1ns/1ps
`default_nettype none
module ebp_ext_mem (
  input wire logic clk,
  input wire logic address_valid_n,
  input wire logic [15:0] lines_out,
  input wire logic [15:0] lines_oe,
  output logic [15:0] drive
);
  logic adv_q = 1'b1;
  logic [15:0] addr_q = 16'h0000;
  logic [15:0] drv_q = 16'h0000;
  assign drive = drv_q;
  // Latch on strobe fall, answer while low, else toggle
  always @(posedge clk) begin
    adv_q <= address_valid_n;
    if (adv_q && !address_valid_n) addr_q <= lines_out & lines_oe;
    drv_q <= !address_valid_n ? addr_q ^ 16'h5a5a : ~drv_q;
  end
endmodule // ebp_ext_mem
`default_nettype wire

/* File: testbench/external_bus_pin_control_tb.sv */
// Self-checking bench for the external bus sequencer
`timescale 1ns/1ps
`default_nettype none
module external_bus_pin_control_tb;
  import ebp_pkg::*;
  localparam int H = 4;
  logic clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, req_external = 1'b0;
  ebp_req_s req_in = '0;
  logic [7:0] ihb = 8'h00;
  logic req_ready, done, adv_n;
  logic [15:0] rdata, lout, loe, mem_drv, lin;
  int err_count = 0, num_checks = 0;
  always #2 clk = ~clk;
  // Each line resolved from the drive enables
  assign lin = (lout & loe) | (mem_drv & ~loe);
  ebp_bus_ctrl #(.HALF_CYCLES(H)) dut (.clk(clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_external(req_external), .req_in(req_in),
    .int_high_byte(ihb), .addr_data_lines_in(lin), .req_ready(req_ready),
    .done(done), .rdata(rdata), .addr_data_lines_out(lout),
    .addr_data_lines_oe(loe), .address_valid_n(adv_n));
  ebp_ext_mem mem (.clk(clk), .address_valid_n(adv_n), .lines_out(lout),
    .lines_oe(loe), .drive(mem_drv));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Expected drive and enable for one phase
  task automatic phase(input ebp_req_s r, input logic dp);
    logic [15:0] d, e;
    d = r.wdata;
    e = r.write ? 16'hffff : 16'h0000;
    if (!r.mode[1] && !dp) begin
      d = r.addr;
      e = 16'hffff;
    end
    if (!r.mode[0]) begin
      d[15:8] = r.mode[1] ? ihb : r.addr[15:8];
      e[15:8] = 8'hff;
    end
    chk(loe, e);
    chk(lout & loe, d & e);
  endtask
  task automatic op(input logic ext, input logic [1:0] m);
    ebp_req_s r;
    logic [15:0] x;
    r = {m, 1'($urandom), 16'($urandom), 16'($urandom)};
    @(posedge clk);
    req_in <= r;
    req_valid <= 1'b1;
    req_external <= ext;
    ihb <= 8'($urandom);
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    chk({15'h0, adv_n}, {15'h0, !ext});
    chk({15'h0, req_ready}, {15'h0, !ext});
    if (ext) phase(r, 1'b0);
    repeat (H) @(posedge clk);
    #1;
    if (ext) phase(r, 1'b1);
    repeat (H) @(posedge clk);
    #1;
    chk({14'h0, done, adv_n}, {14'h0, ext, 1'b1});
    x = ((r.mode[1] ? 16'h0000 : r.addr) ^ 16'h5a5a) &
      (r.mode[0] ? 16'hffff : 16'h00ff);
    if (ext && !r.write) chk(rdata, x);
  endtask
  // Reset, then a mix of modes and internal accesses
  initial begin
    void'($urandom(14));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 40; i++) op(i % 5 != 4, 2'(i));
    give_verdict();
  end
  // Watchdog
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
endmodule // external_bus_pin_control_tb
`default_nettype wire
